// >>> cbsbn_pkg.sv
// constants and carrier types for the secondary status and bus number bank
`default_nettype none
package cbsbn_pkg;
  // byte offsets in configuration space
  localparam logic [7:0] OFS_SEC_STATUS = 8'h16;
  localparam logic [7:0] OFS_PRIMARY_BUS = 8'h18;
  localparam logic [7:0] OFS_CARD_BUS = 8'h19;
  localparam logic [7:0] OFS_SUBORD_BUS = 8'h1a;
  // status bit positions
  localparam int BIT_BUS_PARITY = 15;
  localparam int BIT_CARD_SYSERR = 14;
  localparam int BIT_MASTER_ABORT = 13;
  localparam int BIT_RECV_TABORT = 12;
  localparam int BIT_SIG_TABORT = 11;
  localparam int BIT_TIMING_HI = 10;
  localparam int BIT_TIMING_LO = 9;
  localparam int BIT_MASTER_DPAR = 8;
  localparam int NUM_FLAGS = 6;
  // fixed field values
  localparam logic [1:0] SELECT_TIMING_CODE = 2'h1;
  localparam logic [7:0] BUS_NUM_RESET = 8'h00;
  localparam logic [15:0] STATUS_RESET = 16'h0200;
  // one configuration access from the host
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cbsbn_cfg_req_type;
  // hardware event strobes from the card engine
  typedef struct packed {
    logic bus_parity_err;
    logic card_system_error_signal;
    logic master_abort;
    logic recv_target_abort;
    logic sig_target_abort;
    logic card_parity_error_signal;
    logic master_in_data_phase;
  } cbsbn_event_type;
  // forwarding decision for a primary configuration cycle
  typedef enum logic [1:0] {
    CBSBN_FWD_NONE,
    CBSBN_FWD_TYPE0,
    CBSBN_FWD_TYPE1
  } cbsbn_fwd_type;
endpackage
`default_nettype wire

// >>> cbsbn_flag.sv
// one sticky event flag with write-one-to-clear
`default_nettype none
module cbsbn_flag (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // set and clear
  input wire logic set_in,
  input wire logic clr_in,
  // state
  output logic flag_out
);
  logic next_flag;
  // set beats clear in the same cycle
  always_comb begin
    next_flag = flag_out;
    if (clr_in) begin
      next_flag = 1'b0;
    end
    if (set_in) begin
      next_flag = 1'b1;
    end
  end
  // registered flag; reset clears it
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      flag_out <= 1'b0;
    end else begin
      flag_out <= next_flag;
    end
  end
endmodule
`default_nettype wire

// >>> cbsbn_bank.sv
// secondary status, bus number registers and configuration forwarding
`default_nettype none
module cbsbn_bank (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // configuration access
  input wire cbsbn_pkg::cbsbn_cfg_req_type cfg_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  // card engine events and control
  input wire cbsbn_pkg::cbsbn_event_type event_in,
  input wire logic parity_resp_en_in,
  // configuration cycle forwarding
  input wire logic fwd_req_in,
  input wire logic [7:0] fwd_bus_in,
  output cbsbn_pkg::cbsbn_fwd_type fwd_out,
  // bus numbers for the forwarding datapath
  output logic [7:0] primary_bus_num_out,
  output logic [7:0] card_bus_num_out,
  output logic [7:0] subord_bus_num_out
);
  logic [7:0] primary_bus_num;
  logic [7:0] card_bus_num;
  logic [7:0] subord_bus_num;
  logic [7:0] next_primary_bus_num;
  logic [7:0] next_card_bus_num;
  logic [7:0] next_subord_bus_num;
  logic [cbsbn_pkg::NUM_FLAGS-1:0] flag_set;
  logic [cbsbn_pkg::NUM_FLAGS-1:0] flag_clr;
  logic [cbsbn_pkg::NUM_FLAGS-1:0] flags;
  logic [15:0] status_word;
  logic wr_status;
  logic [15:0] next_rdata;
  logic next_rvalid;
  cbsbn_pkg::cbsbn_fwd_type next_fwd;

  // event sources, flag index 5 down to 0 maps bits 15..11 and 8
  always_comb begin
    flag_set[5] = event_in.bus_parity_err;
    flag_set[4] = event_in.card_system_error_signal;
    flag_set[3] = event_in.master_abort;
    flag_set[2] = event_in.recv_target_abort;
    flag_set[1] = event_in.sig_target_abort;
    flag_set[0] = event_in.card_parity_error_signal &
                  event_in.master_in_data_phase &
                  parity_resp_en_in;
  end

  // write-one-to-clear decode; zeros leave flags alone
  assign wr_status = cfg_in.wr && (cfg_in.addr == cbsbn_pkg::OFS_SEC_STATUS);
  assign flag_clr = {cfg_in.wdata[cbsbn_pkg::BIT_BUS_PARITY:
                                  cbsbn_pkg::BIT_SIG_TABORT],
                     cfg_in.wdata[cbsbn_pkg::BIT_MASTER_DPAR]} &
                    {cbsbn_pkg::NUM_FLAGS{wr_status}};

  genvar gi;
  generate
    for (gi = 0; gi < cbsbn_pkg::NUM_FLAGS; gi++) begin : g_flag
      cbsbn_flag cbsbn_flag_inst (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .set_in(flag_set[gi]),
        .clr_in(flag_clr[gi]),
        .flag_out(flags[gi])
      );
    end
  endgenerate

  // status image; hardwired fields cannot be written
  always_comb begin
    status_word = cbsbn_pkg::STATUS_RESET;
    // bits 7..0 stay zero
    status_word[cbsbn_pkg::BIT_BUS_PARITY:cbsbn_pkg::BIT_SIG_TABORT] =
      flags[5:1];
    status_word[cbsbn_pkg::BIT_TIMING_HI:cbsbn_pkg::BIT_TIMING_LO] =
      cbsbn_pkg::SELECT_TIMING_CODE;
    status_word[cbsbn_pkg::BIT_MASTER_DPAR] = flags[0];
  end

  // bus number registers, byte wide in the low lanes
  always_comb begin
    next_primary_bus_num = primary_bus_num;
    next_card_bus_num = card_bus_num;
    next_subord_bus_num = subord_bus_num;
    if (cfg_in.wr) begin
      unique case (cfg_in.addr)
        cbsbn_pkg::OFS_PRIMARY_BUS: begin
          next_primary_bus_num = cfg_in.wdata[7:0];
        end
        cbsbn_pkg::OFS_CARD_BUS: begin
          next_card_bus_num = cfg_in.wdata[7:0];
        end
        cbsbn_pkg::OFS_SUBORD_BUS: begin
          next_subord_bus_num = cfg_in.wdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // registered read data; unmapped offsets read zero
  always_comb begin
    next_rvalid = cfg_in.rd;
    next_rdata = 16'h0000;
    if (cfg_in.rd) begin
      unique case (cfg_in.addr)
        cbsbn_pkg::OFS_SEC_STATUS: next_rdata = status_word;
        cbsbn_pkg::OFS_PRIMARY_BUS: next_rdata = {8'h00, primary_bus_num};
        cbsbn_pkg::OFS_CARD_BUS: next_rdata = {8'h00, card_bus_num};
        cbsbn_pkg::OFS_SUBORD_BUS: next_rdata = {8'h00, subord_bus_num};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // forwarding decision uses all three numbers together
  always_comb begin
    next_fwd = cbsbn_pkg::CBSBN_FWD_NONE;
    if (fwd_req_in) begin
      if (fwd_bus_in == card_bus_num &&
          fwd_bus_in != primary_bus_num) begin
        next_fwd = cbsbn_pkg::CBSBN_FWD_TYPE0;
      end else if (fwd_bus_in > card_bus_num &&
                   fwd_bus_in <= subord_bus_num &&
                   fwd_bus_in != primary_bus_num) begin
        next_fwd = cbsbn_pkg::CBSBN_FWD_TYPE1;
      end
    end
  end

  // bus numbers, read data and forwarding; reset is synchronous so outputs settle on one edge
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      primary_bus_num <= cbsbn_pkg::BUS_NUM_RESET;
      card_bus_num <= cbsbn_pkg::BUS_NUM_RESET;
      subord_bus_num <= cbsbn_pkg::BUS_NUM_RESET;
      rdata_out <= 16'h0000;
      rvalid_out <= 1'b0;
      fwd_out <= cbsbn_pkg::CBSBN_FWD_NONE;
    end else begin
      primary_bus_num <= next_primary_bus_num;
      card_bus_num <= next_card_bus_num;
      subord_bus_num <= next_subord_bus_num;
      rdata_out <= next_rdata;
      rvalid_out <= next_rvalid;
      fwd_out <= next_fwd;
    end
  end

  assign primary_bus_num_out = primary_bus_num;
  assign card_bus_num_out = card_bus_num;
  assign subord_bus_num_out = subord_bus_num;

  // checks; steps of a request are named sequences
  sequence s_card_write;
    cfg_in.wr && cfg_in.addr == cbsbn_pkg::OFS_CARD_BUS;
  endsequence
  sequence s_primary_write;
    cfg_in.wr && cfg_in.addr == cbsbn_pkg::OFS_PRIMARY_BUS;
  endsequence
  sequence s_subord_write;
    cfg_in.wr && cfg_in.addr == cbsbn_pkg::OFS_SUBORD_BUS;
  endsequence
  sequence s_status_read;
    cfg_in.rd && cfg_in.addr == cbsbn_pkg::OFS_SEC_STATUS;
  endsequence
  // flag was clear, then shows set one edge later
  sequence s_dpar_rise;
    !status_word[cbsbn_pkg::BIT_MASTER_DPAR] ##1
    status_word[cbsbn_pkg::BIT_MASTER_DPAR];
  endsequence
  a_parity_sets: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    event_in.bus_parity_err |=> status_word[cbsbn_pkg::BIT_BUS_PARITY])
    else $error("parity flag not set");
  a_syserr_sets: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    event_in.card_system_error_signal |=>
    status_word[cbsbn_pkg::BIT_CARD_SYSERR])
    else $error("system error flag not set");
  a_mabort_sets: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    event_in.master_abort |=> status_word[cbsbn_pkg::BIT_MASTER_ABORT])
    else $error("master abort flag not set");
  a_rtabort_sets: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    event_in.recv_target_abort |=> status_word[cbsbn_pkg::BIT_RECV_TABORT])
    else $error("received target abort flag not set");
  a_stabort_sets: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    event_in.sig_target_abort |=> status_word[cbsbn_pkg::BIT_SIG_TABORT])
    else $error("signaled target abort flag not set");
  a_fixed_bits: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    s_status_read |=>
    rdata_out[cbsbn_pkg::BIT_TIMING_HI:cbsbn_pkg::BIT_TIMING_LO] ==
    cbsbn_pkg::SELECT_TIMING_CODE)
    else $error("hardwired timing bits wrong");
  a_low_zero: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    s_status_read |=> rdata_out[7:0] == 8'h00)
    else $error("low status bits not zero");
  a_dpar_gated: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    s_dpar_rise |-> $past(event_in.card_parity_error_signal) &&
    $past(event_in.master_in_data_phase) && $past(parity_resp_en_in))
    else $error("data parity flag set without all conditions");
  a_dpar_sets: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    event_in.card_parity_error_signal && event_in.master_in_data_phase &&
    parity_resp_en_in |=> status_word[cbsbn_pkg::BIT_MASTER_DPAR])
    else $error("data parity flag not set");
  a_card_bus_wr: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    s_card_write |=> card_bus_num == $past(cfg_in.wdata[7:0]))
    else $error("card bus number not written");
  a_primary_wr: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    s_primary_write |=> primary_bus_num == $past(cfg_in.wdata[7:0]))
    else $error("primary bus number not written");
  a_subord_wr: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    s_subord_write |=> subord_bus_num == $past(cfg_in.wdata[7:0]))
    else $error("subordinate bus number not written");
  a_zero_keeps: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    wr_status && !cfg_in.wdata[cbsbn_pkg::BIT_BUS_PARITY] &&
    status_word[cbsbn_pkg::BIT_BUS_PARITY] |=>
    status_word[cbsbn_pkg::BIT_BUS_PARITY])
    else $error("writing zero cleared a flag");
  a_type0_fwd: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    fwd_req_in && fwd_bus_in == card_bus_num &&
    fwd_bus_in != primary_bus_num |=>
    fwd_out == cbsbn_pkg::CBSBN_FWD_TYPE0)
    else $error("type 0 conversion missed");
  a_primary_kept: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    fwd_req_in && fwd_bus_in == primary_bus_num |=>
    fwd_out == cbsbn_pkg::CBSBN_FWD_NONE)
    else $error("cycle for the primary bus forwarded");
endmodule
`default_nettype wire

// >>> cbsbn_host.sv
// host model issuing configuration reads and writes to the bank
`default_nettype none
module cbsbn_host (
  // clock
  input wire logic mclk_in,
  // read answer from the bank
  input wire logic rvalid_in,
  input wire logic [15:0] rdata_in,
  // configuration request
  output cbsbn_pkg::cbsbn_cfg_req_type cfg_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cfg_out = '0;
  // one-cycle request; idle bus shows inverted leftovers, never stale data
  task automatic put(input logic r, input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge mclk_in);
    cfg_out <= '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge mclk_in);
    cfg_out <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // software programs bus numbers
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    put(1'b0, 1'b1, a, d);
  endtask
  // bounded wait for the one-cycle answer
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic ok);
    int n;
    n = 0;
    put(1'b1, 1'b0, a, 16'h0000);
    @(negedge mclk_in);
    while (rvalid_in !== 1'b1 && n < 3) begin
      n++;
      @(negedge mclk_in);
    end
    d = rdata_in;
    ok = (rvalid_in === 1'b1);
  endtask
endmodule
`default_nettype wire

// >>> cbsbn_bank_tb.sv
// self-checking bench for the status and bus number bank
`default_nettype none
module cbsbn_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  cbsbn_pkg::cbsbn_cfg_req_type cfg;
  cbsbn_pkg::cbsbn_event_type ev = '0;
  logic pre_en = 1'b0;
  logic fwd_req = 1'b0;
  logic [7:0] fwd_bus = 8'h00;
  logic [15:0] rdata;
  logic rvalid;
  cbsbn_pkg::cbsbn_fwd_type fwd;
  logic [7:0] pbus;
  logic [7:0] cbus;
  logic [7:0] sbus;
  int err_total = 0;
  int checks = 0;
  // 10 MHz clock
  initial forever #50 mclk_in = ~mclk_in;
  cbsbn_bank cbsbn_bank_inst (.mclk_in(mclk_in), .srst_in(srst_in),
    .cfg_in(cfg), .rdata_out(rdata), .rvalid_out(rvalid), .event_in(ev),
    .parity_resp_en_in(pre_en), .fwd_req_in(fwd_req), .fwd_bus_in(fwd_bus),
    .fwd_out(fwd), .primary_bus_num_out(pbus), .card_bus_num_out(cbus),
    .subord_bus_num_out(sbus));
  cbsbn_host cbsbn_host_inst (.mclk_in(mclk_in), .rvalid_in(rvalid),
    .rdata_in(rdata), .cfg_out(cfg));
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // read through the host; a missing answer ends the run
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    cbsbn_host_inst.rd(a, d, ok);
    if (ok !== 1'b1) begin
      err_total++;
      end_sim();
    end else begin
      chk(d, e);
    end
  endtask
  // single-cycle event strobe
  task automatic pulse(input logic [6:0] v);
    @(posedge mclk_in);
    ev <= v;
    @(posedge mclk_in);
    ev <= '0;
  endtask
  // decision shows one cycle after the request edge
  task automatic fchk(input logic [7:0] b, input cbsbn_pkg::cbsbn_fwd_type e);
    @(posedge mclk_in);
    fwd_req <= 1'b1;
    fwd_bus <= b;
    @(posedge mclk_in);
    fwd_req <= 1'b0;
    fwd_bus <= ~b;
    @(negedge mclk_in);
    chk({14'h0000, fwd}, {14'h0000, e});
  endtask
  initial begin
    logic [15:0] e;
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'b0;
    rchk(8'h16, 16'h0200);
    rchk(8'h18, 16'h0000);
    rchk(8'h19, 16'h0000);
    rchk(8'h1a, 16'h0000);
    // fixed bits must ignore writes
    cbsbn_host_inst.wr(8'h16, 16'h07ff);
    rchk(8'h16, 16'h0200);
    cbsbn_host_inst.wr(8'h1b, 16'h00ff);
    rchk(8'h1b, 16'h0000);
    $display("test reset and fixed bits done");
    // upper write byte is dropped for bus numbers
    cbsbn_host_inst.wr(8'h18, 16'hffa5);
    cbsbn_host_inst.wr(8'h19, 16'h003c);
    cbsbn_host_inst.wr(8'h1a, 16'h007e);
    rchk(8'h18, 16'h00a5);
    rchk(8'h19, 16'h003c);
    rchk(8'h1a, 16'h007e);
    chk({pbus, cbus}, 16'ha53c);
    chk({8'h00, sbus}, 16'h007e);
    $display("test bus numbers done");
    // each of the five event flags at bits 15..11: set, survives a zero write, clears on one
    for (int i = 0; i < 5; i++) begin
      e = 16'h0200 | (16'h8000 >> i);
      pulse(7'h40 >> i);
      rchk(8'h16, e);
      cbsbn_host_inst.wr(8'h16, 16'h0000);
      rchk(8'h16, e);
      cbsbn_host_inst.wr(8'h16, 16'h8000 >> i);
      rchk(8'h16, 16'h0200);
    end
    $display("test event flags done");
    // master parity needs all three conditions together
    pulse(7'h03);
    rchk(8'h16, 16'h0200);
    @(posedge mclk_in);
    pre_en <= 1'b1;
    pulse(7'h02);
    rchk(8'h16, 16'h0200);
    pulse(7'h03);
    rchk(8'h16, 16'h0300);
    cbsbn_host_inst.wr(8'h16, 16'h0100);
    rchk(8'h16, 16'h0200);
    // set and clear on the same edge
    fork
      cbsbn_host_inst.wr(8'h16, 16'h2000);
      pulse(7'h10);
    join
    rchk(8'h16, 16'h2200);
    $display("test parity and collision done");
    fchk(8'h3c, cbsbn_pkg::CBSBN_FWD_TYPE0);
    fchk(8'h3d, cbsbn_pkg::CBSBN_FWD_TYPE1);
    fchk(8'h7e, cbsbn_pkg::CBSBN_FWD_TYPE1);
    fchk(8'h7f, cbsbn_pkg::CBSBN_FWD_NONE);
    fchk(8'h3b, cbsbn_pkg::CBSBN_FWD_NONE);
    fchk(8'ha5, cbsbn_pkg::CBSBN_FWD_NONE);
    // the primary number inside the range must still not be forwarded
    cbsbn_host_inst.wr(8'h18, 16'h0050);
    fchk(8'h50, cbsbn_pkg::CBSBN_FWD_NONE);
    fchk(8'h4f, cbsbn_pkg::CBSBN_FWD_TYPE1);
    $display("test forwarding done");
    // mid-run reset returns flags and bus numbers to reset values
    @(posedge mclk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'b0;
    rchk(8'h16, 16'h0200);
    rchk(8'h18, 16'h0000);
    rchk(8'h19, 16'h0000);
    rchk(8'h1a, 16'h0000);
    fchk(8'h00, cbsbn_pkg::CBSBN_FWD_NONE);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
`default_nettype wire
